// ### acr_pkg.sv
`default_nettype none
package acr_pkg;
  // Serial word layout
  localparam int ADDR_W = 5;
  localparam int DATA_W = 11;
  localparam int WORD_W = 16;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'hf;
  localparam int ADDR_LSB = DATA_W;
  localparam int NUM_REGS = 8;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_POWER = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_TIMING = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_ORDER = 5'h09;
  localparam logic [ADDR_W-1:0] ADDR_FORMAT = 5'h0a;
  localparam logic [ADDR_W-1:0] ADDR_PAT_LOW = 5'h0b;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_PAT = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_LVDS = 5'h0e;
  localparam logic [ADDR_W-1:0] ADDR_CMOS = 5'h0f;

  // Register slot indexes
  localparam int IDX_POWER = 0;
  localparam int IDX_TIMING = 1;
  localparam int IDX_ORDER = 2;
  localparam int IDX_FORMAT = 3;
  localparam int IDX_PAT_LOW = 4;
  localparam int IDX_GAIN_PAT = 5;
  localparam int IDX_LVDS = 6;
  localparam int IDX_CMOS = 7;

  localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REGS] = '{
    ADDR_POWER, ADDR_TIMING, ADDR_ORDER, ADDR_FORMAT,
    ADDR_PAT_LOW, ADDR_GAIN_PAT, ADDR_LVDS, ADDR_CMOS};

  // Bits kept per register; reset bit and reserved bits are never stored
  localparam logic [DATA_W-1:0] REG_MASK [NUM_REGS] = '{
    11'h725, 11'h700, 11'h400, 11'h4e0,
    11'h7f0, 11'h71f, 11'h3ff, 11'h0f0};

  localparam logic [DATA_W-1:0] REG_DEFAULT = 11'h000;

  // Field positions
  localparam int STBY_BIT = 0;
  localparam int CLKOUT_PD_BIT = 2;
  localparam int SW_RESET_BIT = 4;
  localparam int EXT_REF_BIT = 5;
  localparam int LVDS_SEL_BIT = 8;
  localparam int COARSE_BIT = 9;
  localparam int OBUF_PD_BIT = 10;
  localparam int CLKOUT_POSN_BIT = 8;
  localparam int CLKOUT_EDGE_BIT = 9;
  localparam int DATA_POSN_BIT = 10;
  localparam int BYTE_WISE_BIT = 10;
  localparam int FORMAT_BIT = 10;
  localparam int PATTERN_LSB = 5;
  localparam int PATTERN_W = 3;
  localparam int PAT_LOW_LSB = 4;
  localparam int PAT_LOW_W = 7;
  localparam int PAT_HIGH_LSB = 0;
  localparam int PAT_HIGH_W = 5;
  localparam int FINE_GAIN_LSB = 8;
  localparam int FINE_GAIN_W = 3;
  localparam int DATA_DOUBLE_BIT = 0;
  localparam int CLK_DOUBLE_BIT = 1;
  localparam int CURRENT_LSB = 2;
  localparam int CURRENT_W = 2;
  localparam int CLK_TERM_LSB = 4;
  localparam int DATA_TERM_LSB = 7;
  localparam int TERM_W = 3;
  localparam int DRIVE_LSB = 4;
  localparam int DRIVE_W = 4;

  // Output lanes
  localparam int SAMPLE_W = 14;
  localparam int LANE_W = 8;
  localparam int LOW_BYTE_W = 8;
endpackage
`default_nettype wire

// ### acr_serial_shift.sv
`timescale 1ns/100ps
`default_nettype none
module acr_serial_shift
(
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic serial_enable_n,
  input wire logic serial_data_in,
  output logic [acr_pkg::WORD_W-1:0] word_hold,
  output logic word_toggle
);
  logic [acr_pkg::CNT_W-1:0] bit_count;
  logic [acr_pkg::WORD_W-2:0] shift;
  wire last_bit = (bit_count == acr_pkg::LAST_BIT);

  // Deasserted enable restarts framing, so a short tail never commits
  always_ff @(negedge link_clk or posedge serial_enable_n or negedge reset_n)
  begin
    if (!reset_n || serial_enable_n)
      bit_count <= '0;
    else
      bit_count <= bit_count + 1'b1;
  end

  always_ff @(negedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
      shift <= '0;
    else if (!serial_enable_n)
      shift <= {shift[acr_pkg::WORD_W-3:0], serial_data_in};
  end

  // Held word stays still for 15 link edges, long enough to cross
  always_ff @(negedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      word_hold <= '0;
      word_toggle <= 1'b0;
    end
    else if (!serial_enable_n && last_bit)
    begin
      word_hold <= {shift, serial_data_in};
      word_toggle <= ~word_toggle;
    end
  end
endmodule // acr_serial_shift
`default_nettype wire

// ### acr_lane_map.sv
`timescale 1ns/100ps
`default_nettype none
module acr_lane_map
(
  input wire logic [acr_pkg::SAMPLE_W-1:0] sample,
  input wire logic byte_wise,
  output logic [acr_pkg::LANE_W-1:0] rise_lane,
  output logic [acr_pkg::LANE_W-1:0] fall_lane
);
  logic [acr_pkg::LANE_W-1:0] even_bits;
  logic [acr_pkg::LANE_W-1:0] odd_bits;

  always_comb
  begin
    even_bits = '0;
    odd_bits = '0;
    for (int i = 0; i < acr_pkg::SAMPLE_W / 2; i++)
    begin
      even_bits[i] = sample[2*i];
      odd_bits[i] = sample[2*i+1];
    end
  end

  wire [acr_pkg::LANE_W-1:0] low_byte = sample[acr_pkg::LOW_BYTE_W-1:0];
  wire [acr_pkg::LANE_W-1:0] high_part =
    {{(acr_pkg::LANE_W*2-acr_pkg::SAMPLE_W){1'b0}},
     sample[acr_pkg::SAMPLE_W-1:acr_pkg::LOW_BYTE_W]};

  assign rise_lane = byte_wise ? low_byte : even_bits;
  assign fall_lane = byte_wise ? high_part : odd_bits;
endmodule // acr_lane_map
`default_nettype wire

// ### acr_config_bank.sv
`timescale 1ns/100ps
`default_nettype none
module acr_config_bank
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic serial_enable_n,
  input wire logic serial_data_in,
  input wire logic register_reset,
  input wire logic [acr_pkg::SAMPLE_W-1:0] sample_data,
  output logic adc_standby,
  output logic clkout_buffer_off,
  output logic clkout_oe,
  output logic data_oe,
  output logic external_reference,
  output logic lvds_mode,
  output logic coarse_gain_high,
  output logic clkout_delayed,
  output logic capture_on_falling,
  output logic data_half_delay,
  output logic byte_wise_order,
  output logic straight_binary,
  output logic [acr_pkg::PATTERN_W-1:0] test_pattern,
  output logic [acr_pkg::PAT_LOW_W+acr_pkg::PAT_HIGH_W-1:0] custom_pattern,
  output logic [acr_pkg::FINE_GAIN_W-1:0] fine_gain,
  output logic [acr_pkg::TERM_W-1:0] lvds_data_term,
  output logic [acr_pkg::TERM_W-1:0] lvds_clk_term,
  output logic [acr_pkg::CURRENT_W-1:0] lvds_current,
  output logic lvds_clk_double,
  output logic lvds_data_double,
  output logic [acr_pkg::DRIVE_W-1:0] cmos_drive,
  output logic [acr_pkg::LANE_W-1:0] lane_rise,
  output logic [acr_pkg::LANE_W-1:0] lane_fall
);
  logic [acr_pkg::WORD_W-1:0] word_hold;
  logic word_toggle;
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic rst_caught;
  logic rst_s1;
  logic rst_s2;
  logic [acr_pkg::DATA_W-1:0] cfg [acr_pkg::NUM_REGS];
  logic [acr_pkg::LANE_W-1:0] map_rise;
  logic [acr_pkg::LANE_W-1:0] map_fall;

  // Link side: framing and shifting run on the serial clock
  acr_serial_shift u_shift
  (
    .link_clk(link_clk),
    .reset_n(reset_n),
    .serial_enable_n(serial_enable_n),
    .serial_data_in(serial_data_in),
    .word_hold(word_hold),
    .word_toggle(word_toggle)
  );

  // Toggle crossing; third stage only feeds the edge detector
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end
    else
    begin
      tog_s1 <= word_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  // Reset pin pulse may be shorter than a clk period, so catch it first
  always_ff @(posedge clk or posedge register_reset or negedge reset_n)
  begin
    if (!reset_n)
      rst_caught <= 1'b0;
    else if (register_reset)
      rst_caught <= 1'b1;
    else if (rst_s2)
      rst_caught <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= rst_caught;
      rst_s2 <= rst_s1;
    end
  end

  // Word is stable long before the toggle arrives here
  wire wr_stb = tog_s2 ^ tog_s3;
  wire [acr_pkg::ADDR_W-1:0] wr_addr = word_hold[acr_pkg::WORD_W-1:acr_pkg::ADDR_LSB];
  wire [acr_pkg::DATA_W-1:0] wr_data = word_hold[acr_pkg::DATA_W-1:0];
  wire hit_power = wr_stb && (wr_addr == acr_pkg::ADDR_POWER);
  wire sw_reset = hit_power && wr_data[acr_pkg::SW_RESET_BIT];
  wire hw_reset = rst_s2;
  wire load_defaults = sw_reset || hw_reset;

  // Whole register replaced by one word; unmapped addresses are dropped
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < acr_pkg::NUM_REGS; i++)
        cfg[i] <= acr_pkg::REG_DEFAULT;
    end
    else
    begin
      for (int i = 0; i < acr_pkg::NUM_REGS; i++)
      begin
        if (load_defaults)
          cfg[i] <= acr_pkg::REG_DEFAULT;
        else if (wr_stb && wr_addr == acr_pkg::REG_ADDR[i])
          cfg[i] <= wr_data & acr_pkg::REG_MASK[i];
      end
    end
  end

  wire [acr_pkg::DATA_W-1:0] r_pow = cfg[acr_pkg::IDX_POWER];
  wire [acr_pkg::DATA_W-1:0] r_tim = cfg[acr_pkg::IDX_TIMING];
  wire [acr_pkg::DATA_W-1:0] r_ord = cfg[acr_pkg::IDX_ORDER];
  wire [acr_pkg::DATA_W-1:0] r_fmt = cfg[acr_pkg::IDX_FORMAT];
  wire [acr_pkg::DATA_W-1:0] r_plo = cfg[acr_pkg::IDX_PAT_LOW];
  wire [acr_pkg::DATA_W-1:0] r_gph = cfg[acr_pkg::IDX_GAIN_PAT];
  wire [acr_pkg::DATA_W-1:0] r_lvd = cfg[acr_pkg::IDX_LVDS];
  wire [acr_pkg::DATA_W-1:0] r_cms = cfg[acr_pkg::IDX_CMOS];

  wire pd_clk_w = r_pow[acr_pkg::CLKOUT_PD_BIT];
  wire pd_obuf_w = r_pow[acr_pkg::OBUF_PD_BIT];
  wire lvds_w = r_pow[acr_pkg::LVDS_SEL_BIT];
  wire next_byte_wise = r_ord[acr_pkg::BYTE_WISE_BIT] && lvds_w;
  wire next_clkout_oe = !(pd_clk_w || pd_obuf_w);
  wire next_data_oe = !pd_obuf_w;

  acr_lane_map u_lane
  (
    .sample(sample_data),
    .byte_wise(next_byte_wise),
    .rise_lane(map_rise),
    .fall_lane(map_fall)
  );

  // Every control output is re-registered so the pins see only flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      adc_standby <= 1'b0;
      clkout_buffer_off <= 1'b0;
      clkout_oe <= 1'b0;
      data_oe <= 1'b0;
      external_reference <= 1'b0;
      lvds_mode <= 1'b0;
      coarse_gain_high <= 1'b0;
      clkout_delayed <= 1'b0;
      capture_on_falling <= 1'b0;
      data_half_delay <= 1'b0;
      byte_wise_order <= 1'b0;
      straight_binary <= 1'b0;
      test_pattern <= '0;
      custom_pattern <= '0;
      fine_gain <= '0;
      lvds_data_term <= '0;
      lvds_clk_term <= '0;
      lvds_current <= '0;
      lvds_clk_double <= 1'b0;
      lvds_data_double <= 1'b0;
      cmos_drive <= '0;
      lane_rise <= '0;
      lane_fall <= '0;
    end
    else
    begin
      adc_standby <= r_pow[acr_pkg::STBY_BIT];
      clkout_buffer_off <= pd_clk_w || pd_obuf_w;
      clkout_oe <= next_clkout_oe;
      data_oe <= next_data_oe;
      external_reference <= r_pow[acr_pkg::EXT_REF_BIT];
      lvds_mode <= lvds_w;
      coarse_gain_high <= r_pow[acr_pkg::COARSE_BIT];
      clkout_delayed <= r_tim[acr_pkg::CLKOUT_POSN_BIT];
      capture_on_falling <= r_tim[acr_pkg::CLKOUT_EDGE_BIT];
      data_half_delay <= r_tim[acr_pkg::DATA_POSN_BIT];
      byte_wise_order <= next_byte_wise;
      straight_binary <= r_fmt[acr_pkg::FORMAT_BIT];
      test_pattern <= r_fmt[acr_pkg::PATTERN_LSB +: acr_pkg::PATTERN_W];
      custom_pattern <= {r_gph[acr_pkg::PAT_HIGH_LSB +: acr_pkg::PAT_HIGH_W],
                         r_plo[acr_pkg::PAT_LOW_LSB +: acr_pkg::PAT_LOW_W]};
      fine_gain <= r_gph[acr_pkg::FINE_GAIN_LSB +: acr_pkg::FINE_GAIN_W];
      lvds_data_term <= r_lvd[acr_pkg::DATA_TERM_LSB +: acr_pkg::TERM_W];
      lvds_clk_term <= r_lvd[acr_pkg::CLK_TERM_LSB +: acr_pkg::TERM_W];
      lvds_current <= r_lvd[acr_pkg::CURRENT_LSB +: acr_pkg::CURRENT_W];
      lvds_clk_double <= r_lvd[acr_pkg::CLK_DOUBLE_BIT];
      lvds_data_double <= r_lvd[acr_pkg::DATA_DOUBLE_BIT];
      cmos_drive <= r_cms[acr_pkg::DRIVE_LSB +: acr_pkg::DRIVE_W];
      lane_rise <= map_rise;
      lane_fall <= map_fall;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  wire hit_timing = wr_stb && (wr_addr == acr_pkg::ADDR_TIMING);
  wire [acr_pkg::LANE_W-1:0] samp_low = sample_data[acr_pkg::LOW_BYTE_W-1:0];
  wire samp_b0 = sample_data[0];
  wire samp_b1 = sample_data[1];

  a_commit_single:
    assert property (wr_stb |=> !wr_stb)
    else $error("commit strobe lasted more than one cycle");

  a_word_loads_all:
    assert property ((hit_power && !load_defaults) |=>
      r_pow == ($past(wr_data) & acr_pkg::REG_MASK[acr_pkg::IDX_POWER]))
    else $error("register did not take the whole word");

  a_sw_reset_clears:
    assert property (sw_reset |=> (r_pow == acr_pkg::REG_DEFAULT)
      && (r_tim == acr_pkg::REG_DEFAULT) && !r_pow[acr_pkg::SW_RESET_BIT])
    else $error("software reset did not restore defaults");

  a_standby_follows:
    assert property ((hit_power && !load_defaults && wr_data[acr_pkg::STBY_BIT])
      |=> ##1 adc_standby)
    else $error("standby not entered two cycles after write");

  a_clk_tristate:
    assert property ($past(pd_clk_w) |-> !clkout_oe && clkout_buffer_off)
    else $error("clock pin driven while its buffer is off");

  a_obuf_disable:
    assert property ($past(pd_obuf_w) |-> !clkout_oe && !data_oe)
    else $error("outputs enabled while buffers powered down");

  a_obuf_enable:
    assert property (($past(reset_n) && !$past(pd_obuf_w)) |-> data_oe)
    else $error("data outputs disabled while buffers powered up");

  a_clk_pd_data:
    assert property (($past(reset_n) && $past(pd_clk_w) && !$past(pd_obuf_w)) |-> data_oe)
    else $error("data outputs affected by clock buffer power-down");

  a_clk_position:
    assert property ((hit_timing && !load_defaults) |=>
      ##1 clkout_delayed == $past(wr_data[acr_pkg::CLKOUT_POSN_BIT], 2))
    else $error("clock position bit not applied");

  a_capture_edge:
    assert property ((hit_timing && !load_defaults) |=>
      ##1 capture_on_falling == $past(wr_data[acr_pkg::CLKOUT_EDGE_BIT], 2))
    else $error("capture edge bit not applied");

  a_data_position:
    assert property ((hit_timing && !load_defaults) |=>
      ##1 data_half_delay == $past(wr_data[acr_pkg::DATA_POSN_BIT], 2))
    else $error("data position bit not applied");

  a_order_ddr_only:
    assert property (!lvds_w |=> !byte_wise_order)
    else $error("byte-wise order active outside DDR mode");

  a_lane_bitwise:
    assert property (!next_byte_wise |=>
      lane_rise[0] == $past(samp_b0) && lane_fall[0] == $past(samp_b1))
    else $error("bit-wise lanes misplaced");

  a_lane_bytewise:
    assert property (next_byte_wise |=> lane_rise == $past(samp_low))
    else $error("byte-wise low byte misplaced");

  a_hw_reset_loads:
    assert property (hw_reset |=> r_pow == acr_pkg::REG_DEFAULT)
    else $error("reset pin did not restore defaults");
endmodule // acr_config_bank
`default_nettype wire

// ### acr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module acr_host_model
(
  output logic link_clk,
  output logic serial_enable_n,
  output logic serial_data_in
);
  // Serial clock idles low and only runs inside a frame
  initial
  begin
    link_clk = 1'b0;
    serial_enable_n = 1'b1;
    serial_data_in = 1'b1;
  end

  // Data changes on the rise, so setup and hold both equal half a period
  task automatic shift_bits(input logic [15:0] w, input int nbits, input int half);
    for (int i = 15; i > 15 - nbits; i--)
    begin
      serial_data_in = w[i];
      link_clk = 1'b1;
      #(half);
      link_clk = 1'b0;
      #(half);
    end
  endtask

  // Odd phase offset keeps the link unrelated to the system clock
  task automatic frame(input logic [15:0] w0, input logic [15:0] w1, input int nwords,
                       input int extra, input int half);
    #7;
    serial_enable_n = 1'b0;
    #(half);
    shift_bits(w0, 16, half);
    if (nwords > 1)
      shift_bits(w1, 16, half);
    if (extra > 0)
      shift_bits(w0, extra, half);
    #(half);
    serial_enable_n = 1'b1;
    // Released line shows the inverse, never a held stale bit
    serial_data_in = ~serial_data_in;
  endtask
endmodule // acr_host_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk;
  logic reset_n;
  logic register_reset;
  logic [13:0] sample_data;
  logic link_clk, serial_enable_n, serial_data_in;
  logic adc_standby, clkout_buffer_off, clkout_oe, data_oe, external_reference, lvds_mode;
  logic coarse_gain_high, clkout_delayed, capture_on_falling, data_half_delay;
  logic byte_wise_order, straight_binary, lvds_clk_double, lvds_data_double;
  logic [2:0] test_pattern, fine_gain, lvds_data_term, lvds_clk_term;
  logic [11:0] custom_pattern;
  logic [1:0] lvds_current;
  logic [3:0] cmos_drive;
  logic [7:0] lane_rise, lane_fall;
  logic [11:0] flags;
  logic [28:0] fields;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  assign flags = {adc_standby, clkout_buffer_off, clkout_oe, data_oe, external_reference,
    lvds_mode, coarse_gain_high, clkout_delayed, capture_on_falling, data_half_delay,
    byte_wise_order, straight_binary};
  assign fields = {custom_pattern, fine_gain, lvds_data_term, lvds_clk_term, lvds_current,
    lvds_clk_double, lvds_data_double, cmos_drive};

  acr_host_model i_host (.link_clk(link_clk), .serial_enable_n(serial_enable_n),
    .serial_data_in(serial_data_in));

  acr_config_bank i_dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
    .serial_enable_n(serial_enable_n), .serial_data_in(serial_data_in),
    .register_reset(register_reset), .sample_data(sample_data), .adc_standby(adc_standby),
    .clkout_buffer_off(clkout_buffer_off), .clkout_oe(clkout_oe), .data_oe(data_oe),
    .external_reference(external_reference), .lvds_mode(lvds_mode),
    .coarse_gain_high(coarse_gain_high), .clkout_delayed(clkout_delayed),
    .capture_on_falling(capture_on_falling), .data_half_delay(data_half_delay),
    .byte_wise_order(byte_wise_order), .straight_binary(straight_binary),
    .test_pattern(test_pattern), .custom_pattern(custom_pattern), .fine_gain(fine_gain),
    .lvds_data_term(lvds_data_term), .lvds_clk_term(lvds_clk_term),
    .lvds_current(lvds_current), .lvds_clk_double(lvds_clk_double),
    .lvds_data_double(lvds_data_double), .cmos_drive(cmos_drive), .lane_rise(lane_rise),
    .lane_fall(lane_fall));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Output pins settle within five clocks of the last fall; eight gives margin
  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    @(posedge clk);
    i_host.frame({a, d}, 16'h0000, 1, 0, 40);
    repeat (8) @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] lanes_exp(input logic [13:0] s, input logic byte_mode);
    logic [7:0] r;
    logic [7:0] f;
    r = 8'h00;
    f = 8'h00;
    for (int i = 0; i < 7; i++)
    begin
      r[i] = s[2*i];
      f[i] = s[2*i+1];
    end
    if (byte_mode)
      return {s[7:0], 2'b00, s[13:8]};
    return {r, f};
  endfunction

  task automatic lanes(input logic byte_mode);
    logic [13:0] s [2] = '{14'h2d6b, 14'h1555};
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      sample_data <= s[k];
      repeat (2) @(posedge clk);
      #1;
      check({lane_rise, lane_fall}, lanes_exp(s[k], byte_mode));
    end
  endtask

  task automatic t_power();
    wr(acr_pkg::ADDR_POWER, 11'h325);
    check(flags, 12'hde0);
    wr(acr_pkg::ADDR_POWER, 11'h400);
    check(flags, 12'h400);
    wr(acr_pkg::ADDR_POWER, 11'h004);
    check(flags, 12'h500);
    wr(acr_pkg::ADDR_POWER, 11'h000);
    check(flags, 12'h300);
    $display("done t_power");
  endtask

  task automatic t_timing();
    logic [10:0] d [4] = '{11'h100, 11'h200, 11'h400, 11'h700};
    logic [11:0] e [4] = '{12'h310, 12'h308, 12'h304, 12'h31c};
    for (int k = 0; k < 4; k++)
    begin
      wr(acr_pkg::ADDR_TIMING, d[k]);
      check(flags, e[k]);
    end
    wr(acr_pkg::ADDR_TIMING, 11'h000);
    $display("done t_timing");
  endtask

  // CMOS mode keeps bit-wise lanes even with byte-wise selected
  task automatic t_order();
    wr(acr_pkg::ADDR_ORDER, 11'h400);
    check(byte_wise_order, 1'b0);
    lanes(1'b0);
    wr(acr_pkg::ADDR_POWER, 11'h100);
    check(byte_wise_order, 1'b1);
    lanes(1'b1);
    wr(acr_pkg::ADDR_ORDER, 11'h000);
    lanes(1'b0);
    $display("done t_order");
  endtask

  // Two words in one frame, with trailing bits to drop
  task automatic t_frame();
    @(posedge clk);
    i_host.frame({acr_pkg::ADDR_TIMING, 11'h400}, {acr_pkg::ADDR_FORMAT, 11'h4a0}, 2, 5, 40);
    repeat (8) @(posedge clk);
    #1;
    check(flags, 12'h345);
    check(test_pattern, 3'h5);
    wr(5'h1f, 11'h7ff);
    check(flags, 12'h345);
    $display("done t_frame");
  endtask

  task automatic t_fields();
    wr(acr_pkg::ADDR_PAT_LOW, 11'h5a0);
    wr(acr_pkg::ADDR_GAIN_PAT, 11'h613);
    wr(acr_pkg::ADDR_LVDS, 11'h2b7);
    wr(acr_pkg::ADDR_CMOS, 11'h0b0);
    check(fields, {12'h9da, 3'h6, 3'h5, 3'h3, 2'h1, 1'b1, 1'b1, 4'hb});
    $display("done t_fields");
  endtask

  task automatic t_swreset();
    wr(acr_pkg::ADDR_POWER, 11'h010);
    check(flags, 12'h300);
    check({fields, test_pattern}, 32'h0);
    wr(acr_pkg::ADDR_TIMING, 11'h100);
    check(flags, 12'h310);
    $display("done t_swreset");
  endtask

  task automatic t_pin_reset();
    wr(acr_pkg::ADDR_CMOS, 11'h0f0);
    @(posedge clk);
    register_reset <= 1'b1;
    @(posedge clk);
    register_reset <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check(flags, 12'h300);
    check(cmos_drive, 4'h0);
    wr(acr_pkg::ADDR_POWER, 11'h001);
    check(flags, 12'hb00);
    $display("done t_pin_reset");
  endtask

  // Whole run needs about 1000 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      miscompares++;
      $display("ERROR t=%0t run did not finish", $time);
      wrap_up();
    end
  end

  initial
  begin
    reset_n = 1'b0;
    register_reset = 1'b0;
    sample_data = 14'h0000;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(flags, 12'h300);
    t_power();
    t_timing();
    t_order();
    t_frame();
    t_fields();
    t_swreset();
    t_pin_reset();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
